// ---- core/shrif_adapter.sv ----
// Functional notes
// - Master selected, no pending interrupt: line low
// - Master selected, enabled, pending: line high
// - Slave selected: not-selected state, line low
// - Comreset when selected: busy, clear, link reset
// - Comreset or soft reset deselected: clear devsel
// - Control write no reset: frame, state by pending when selected
// - Control write soft reset: busy, clear, frame
// - Command write selected: busy, clear, command frame
// - Deselected non-diagnostic command: nothing happens
// - Deselected diagnostic: busy, devsel clear, frame
// - Device/head write devsel one: deselect
// - Deselected devsel zero write: reselect by pending
// - Other writes store the task-file byte only
// - Transport update without flag: load shadow only
// - Transport update with flag: pending, maybe interrupt
// - Status read in interrupt state clears pending
// - Other reads keep interrupt pending
// - Transport updates load shadow, state change only with flag
// - Deselected status reads return zero
// - Deselected other reads return shadow value
//
// Purpose: Host adapter task-file emulation with interrupt state machine
// Assumes: Host and transport strobes are same-clock one-cycle pulses
// Notes:   Read data appears one cycle after rd strobe
`timescale 1ns/1ps
`default_nettype none
module shrif_adapter (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   input  wire logic       host_wr_in,
   input  wire logic       host_rd_in,
   input  wire logic       host_ctl_in,
   input  wire logic [2:0] host_addr_in,
   input  wire logic [7:0] host_wdata_in,
   input  wire logic       host_comreset_in,
   input  wire logic       tl_upd_in,
   input  wire logic       tl_ipf_in,
   input  wire logic [7:0] tl_status_in,
   input  wire logic [7:0] tl_devh_in,
   output logic      [7:0] host_rdata_out,
   output logic            host_rvalid_out,
   output logic            host_intrq_out,
   output logic            link_comreset_out,
   output logic            ctl_frame_req_out,
   output logic            cmd_frame_req_out,
   output logic      [7:0] frame_cmd_out,
   output logic      [7:0] frame_devh_out,
   output logic      [7:0] frame_dctl_out,
   output logic      [2:0] state_out
);

   typedef struct packed {
      shrif_pkg::shrif_state_t st;
      logic                    pending_interrupt_flag;
      logic [7:0]              stat;
      logic [7:0]              devh;
      logic [7:0]              dctl;
      logic [7:0]              cmd;
      logic                    intrq;
      logic                    comreset;
      logic                    ctl_req;
      logic                    cmd_req;
      logic                    rd_pend;
      logic                    rd_zero;
      logic                    rd_stat;
   } shrif_regs_t;

   shrif_regs_t r_ff, nxt_r;
   logic        rf_we;
   logic [2:0]  rf_waddr;
   logic [7:0]  rf_wdata;
   logic [7:0]  rf_rdata;

   // Decoded host accesses; ctl flag selects the control block
   logic wr_dctl, wr_cmd, wr_devh, rd_stat, rd_alt, interrupt_disable_bit, pend_int;
   assign wr_dctl  = host_wr_in && host_ctl_in;
   assign wr_cmd   = host_wr_in && !host_ctl_in &&
                     host_addr_in == shrif_pkg::SHRIF_REG_STCMD;
   assign wr_devh  = host_wr_in && !host_ctl_in &&
                     host_addr_in == shrif_pkg::SHRIF_REG_DEVH;
   assign rd_stat  = host_rd_in && !host_ctl_in &&
                     host_addr_in == shrif_pkg::SHRIF_REG_STCMD;
   assign rd_alt   = host_rd_in && host_ctl_in;
   assign interrupt_disable_bit     = r_ff.dctl[shrif_pkg::SHRIF_INTERRUPT_DISABLE_BIT_POS];
   assign pend_int = r_ff.pending_interrupt_flag && !interrupt_disable_bit;

   always_comb begin
      nxt_r          = r_ff;
      nxt_r.comreset = 1'b0;
      nxt_r.ctl_req  = 1'b0;
      nxt_r.cmd_req  = 1'b0;
      nxt_r.rd_pend  = host_rd_in;
      nxt_r.rd_zero  = 1'b0;
      nxt_r.rd_stat  = rd_stat;
      rf_we          = 1'b0;
      rf_waddr       = host_addr_in;
      rf_wdata       = host_wdata_in;
      // Transport updates land in the shadow in any state
      if (tl_upd_in) begin
         nxt_r.stat = tl_status_in;
         nxt_r.devh = tl_devh_in;
         if (tl_ipf_in) begin
            nxt_r.pending_interrupt_flag = 1'b1;
            if (r_ff.st == shrif_pkg::SHRIF_SEL_NOINT && !interrupt_disable_bit)
               nxt_r.st = shrif_pkg::SHRIF_SEL_INT;
         end
      end
      // Host events take precedence over a same-cycle transport update
      if (host_comreset_in) begin
         nxt_r.stat[shrif_pkg::SHRIF_BUSY_POS] = 1'b1;
         nxt_r.pending_interrupt_flag      = 1'b0;
         nxt_r.comreset = 1'b1;
         if (r_ff.st == shrif_pkg::SHRIF_NOTSEL)
            nxt_r.devh[shrif_pkg::SHRIF_DEVSEL_POS] = 1'b0;
         nxt_r.st = shrif_pkg::SHRIF_SEL_NOINT;
      end else if (wr_dctl) begin
         nxt_r.dctl    = host_wdata_in;
         nxt_r.ctl_req = 1'b1;
         if (host_wdata_in[shrif_pkg::SHRIF_SOFT_RESET_BIT_POS]) begin
            nxt_r.stat[shrif_pkg::SHRIF_BUSY_POS] = 1'b1;
            nxt_r.pending_interrupt_flag = 1'b0;
            if (r_ff.st == shrif_pkg::SHRIF_NOTSEL)
               nxt_r.devh[shrif_pkg::SHRIF_DEVSEL_POS] = 1'b0;
            nxt_r.st = shrif_pkg::SHRIF_SEL_NOINT;
         end else if (r_ff.st != shrif_pkg::SHRIF_NOTSEL) begin
            // New interrupt_disable_bit value decides the interrupt state
            nxt_r.st = (r_ff.pending_interrupt_flag && !host_wdata_in[shrif_pkg::SHRIF_INTERRUPT_DISABLE_BIT_POS])
                       ? shrif_pkg::SHRIF_SEL_INT
                       : shrif_pkg::SHRIF_SEL_NOINT;
         end
      end else if (wr_cmd) begin
         if (r_ff.st != shrif_pkg::SHRIF_NOTSEL) begin
            nxt_r.cmd = host_wdata_in;
            nxt_r.stat[shrif_pkg::SHRIF_BUSY_POS] = 1'b1;
            nxt_r.pending_interrupt_flag     = 1'b0;
            nxt_r.cmd_req = 1'b1;
            nxt_r.st      = shrif_pkg::SHRIF_SEL_NOINT;
         end else if (host_wdata_in == shrif_pkg::SHRIF_CMD_DIAG) begin
            nxt_r.cmd = host_wdata_in;
            nxt_r.stat[shrif_pkg::SHRIF_BUSY_POS] = 1'b1;
            nxt_r.devh[shrif_pkg::SHRIF_DEVSEL_POS] = 1'b0;
            nxt_r.pending_interrupt_flag     = 1'b0;
            nxt_r.cmd_req = 1'b1;
            nxt_r.st      = shrif_pkg::SHRIF_SEL_NOINT;
         end
         // Deselected other command: ignored entirely
      end else if (wr_devh) begin
         nxt_r.devh = host_wdata_in;
         if (host_wdata_in[shrif_pkg::SHRIF_DEVSEL_POS])
            nxt_r.st = shrif_pkg::SHRIF_NOTSEL;
         else if (r_ff.st == shrif_pkg::SHRIF_NOTSEL)
            nxt_r.st = pend_int ? shrif_pkg::SHRIF_SEL_INT
                                : shrif_pkg::SHRIF_SEL_NOINT;
      end else if (host_wr_in && !host_ctl_in) begin
         // Plain task-file store, no state or flag change
         rf_we = 1'b1;
      end else if (rd_stat && r_ff.st == shrif_pkg::SHRIF_SEL_INT) begin
         nxt_r.pending_interrupt_flag = 1'b0;
         nxt_r.st  = shrif_pkg::SHRIF_SEL_NOINT;
      end
      // Alternate status never clears pending
      if ((rd_stat || rd_alt) && r_ff.st == shrif_pkg::SHRIF_NOTSEL)
         nxt_r.rd_zero = 1'b1;
      nxt_r.rd_stat = rd_stat || rd_alt;
      nxt_r.intrq = nxt_r.st == shrif_pkg::SHRIF_SEL_INT;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         r_ff.st       <= shrif_pkg::SHRIF_SEL_NOINT;
         r_ff.pending_interrupt_flag      <= 1'b0;
         r_ff.stat     <= shrif_pkg::SHRIF_RST_STAT;
         r_ff.devh     <= shrif_pkg::SHRIF_RST_DEVH;
         r_ff.dctl     <= shrif_pkg::SHRIF_RST_DCTL;
         r_ff.cmd      <= 8'h00;
         r_ff.intrq    <= 1'b0;
         r_ff.comreset <= 1'b0;
         r_ff.ctl_req  <= 1'b0;
         r_ff.cmd_req  <= 1'b0;
         r_ff.rd_pend  <= 1'b0;
         r_ff.rd_zero  <= 1'b0;
         r_ff.rd_stat  <= 1'b0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Low task-file bytes live in the small memory
   shrif_regfile u_regfile (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .we_in      (rf_we),
      .waddr_in   (rf_waddr),
      .wdata_in   (rf_wdata),
      .raddr_in   (host_addr_in),
      .rdata_out  (rf_rdata)
   );

   // Device/head reads come from the shadow copy
   logic       rd_devh_ff;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in)
         rd_devh_ff <= 1'b0;
      else
         rd_devh_ff <= host_rd_in && !host_ctl_in &&
                       host_addr_in == shrif_pkg::SHRIF_REG_DEVH;
   end

   always_comb begin
      if (r_ff.rd_zero)
         host_rdata_out = shrif_pkg::SHRIF_NOTSEL_RD;
      else if (r_ff.rd_stat)
         host_rdata_out = r_ff.stat;
      else if (rd_devh_ff)
         host_rdata_out = r_ff.devh;
      else
         host_rdata_out = rf_rdata;
   end

   assign host_rvalid_out   = r_ff.rd_pend;
   assign host_intrq_out    = r_ff.intrq;
   assign link_comreset_out = r_ff.comreset;
   assign ctl_frame_req_out = r_ff.ctl_req;
   assign cmd_frame_req_out = r_ff.cmd_req;
   assign frame_cmd_out     = r_ff.cmd;
   assign frame_devh_out    = r_ff.devh;
   assign frame_dctl_out    = r_ff.dctl;
   assign state_out         = r_ff.st;

   // Checks
   chk_int_sel: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      host_intrq_out == (r_ff.st == shrif_pkg::SHRIF_SEL_INT))
      else $error("interrupt line disagrees with state");
   chk_int_cond: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      host_intrq_out |-> r_ff.pending_interrupt_flag && !interrupt_disable_bit)
      else $error("interrupt without pending enabled");
   chk_notsel_low: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      r_ff.st == shrif_pkg::SHRIF_NOTSEL |-> !host_intrq_out)
      else $error("interrupt while deselected");
   chk_comreset_eff: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      host_comreset_in |=> link_comreset_out && !r_ff.pending_interrupt_flag &&
      r_ff.stat[shrif_pkg::SHRIF_BUSY_POS] &&
      r_ff.st == shrif_pkg::SHRIF_SEL_NOINT)
      else $error("comreset effects missing");
   chk_cmd_frame: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      wr_cmd && !host_comreset_in && !wr_dctl &&
      r_ff.st != shrif_pkg::SHRIF_NOTSEL |=> cmd_frame_req_out && !r_ff.pending_interrupt_flag)
      else $error("command frame not requested");
   chk_cmd_ignore: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      wr_cmd && !host_comreset_in && r_ff.st == shrif_pkg::SHRIF_NOTSEL &&
      host_wdata_in != shrif_pkg::SHRIF_CMD_DIAG |=> !cmd_frame_req_out &&
      r_ff.st == shrif_pkg::SHRIF_NOTSEL)
      else $error("deselected command acted on");
   chk_stat_clear: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      rd_stat && !host_wr_in && !host_comreset_in && !tl_upd_in &&
      r_ff.st == shrif_pkg::SHRIF_SEL_INT |=> !r_ff.pending_interrupt_flag && !host_intrq_out)
      else $error("status read did not clear");
   chk_notsel_zero: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      (rd_stat || rd_alt) && r_ff.st == shrif_pkg::SHRIF_NOTSEL
      |=> host_rvalid_out && host_rdata_out == 8'h00)
      else $error("deselected status read not zero");
   cov_int: cover property (@(posedge clk_sys_in) $rose(host_intrq_out));
   cov_desel: cover property (@(posedge clk_sys_in)
      r_ff.st == shrif_pkg::SHRIF_NOTSEL);
   cov_diag: cover property (@(posedge clk_sys_in)
      wr_cmd && r_ff.st == shrif_pkg::SHRIF_NOTSEL &&
      host_wdata_in == shrif_pkg::SHRIF_CMD_DIAG);
endmodule : shrif_adapter
`default_nettype wire

// ---- core/shrif_pkg.sv ----
// Purpose: Constants and types for the shadow register interrupt adapter
// Assumes: Eight byte-wide task-file registers, host strobes one cycle wide
// Notes:   Register indices are the legacy task-file order
package shrif_pkg;

   localparam int          SHRIF_NREG      = 8;
   localparam int          SHRIF_AW        = 3;
   // Task-file register indices
   localparam logic [2:0]  SHRIF_REG_DATA  = 3'h0;
   localparam logic [2:0]  SHRIF_REG_FEAT  = 3'h1;
   localparam logic [2:0]  SHRIF_REG_SCNT  = 3'h2;
   localparam logic [2:0]  SHRIF_REG_LBAL  = 3'h3;
   localparam logic [2:0]  SHRIF_REG_LBAM  = 3'h4;
   localparam logic [2:0]  SHRIF_REG_LBAH  = 3'h5;
   localparam logic [2:0]  SHRIF_REG_DEVH  = 3'h6;
   localparam logic [2:0]  SHRIF_REG_STCMD = 3'h7;
   // Field positions
   localparam int          SHRIF_BUSY_POS  = 7;
   localparam int          SHRIF_DEVSEL_POS = 4;
   localparam int          SHRIF_SOFT_RESET_BIT_POS  = 2;
   localparam int          SHRIF_INTERRUPT_DISABLE_BIT_POS  = 1;
   // Command code that reaches a deselected drive
   localparam logic [7:0]  SHRIF_CMD_DIAG  = 8'h90;
   // Values after reset, and the value of deselected status reads
   localparam logic [7:0]  SHRIF_RST_STAT  = 8'h80;
   localparam logic [7:0]  SHRIF_RST_DEVH  = 8'h00;
   localparam logic [7:0]  SHRIF_RST_DCTL  = 8'h00;
   localparam logic [7:0]  SHRIF_NOTSEL_RD = 8'h00;

   typedef enum logic [2:0] {
      SHRIF_SEL_NOINT = 3'b001,
      SHRIF_SEL_INT   = 3'b010,
      SHRIF_NOTSEL    = 3'b100
   } shrif_state_t;

endpackage : shrif_pkg

// ---- core/shrif_regfile.sv ----
// Purpose: Shadow task-file storage with registered read data
// Assumes: One write port, one read port, same clock
// Notes:   A write wins over nothing; caller arbitrates sources
`timescale 1ns/1ps
`default_nettype none
module shrif_regfile #(
   parameter int NREG = shrif_pkg::SHRIF_NREG,
   parameter int AW   = shrif_pkg::SHRIF_AW
) (
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [7:0]    rdata_out
);
   initial begin
      if (NREG > (1 << AW) || NREG < 1)
         $error("shrif_regfile: NREG does not fit AW");
   end

   logic [7:0] mem_ff [NREG];

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NREG; i++)
            mem_ff[i] <= 8'h00;
         rdata_out <= 8'h00;
      end else begin
         if (we_in)
            mem_ff[waddr_in] <= wdata_in;
         rdata_out <= mem_ff[raddr_in];
      end
   end
endmodule : shrif_regfile
`default_nettype wire

// ---- dv/shrif_adapter_tb.sv ----
// Purpose: Self-checking bench for the shadow register interrupt adapter
// Assumes: Outputs react one edge after a strobe; checks at the next fall
// Notes:   Status bit 7 is busy, device/head bit 4 selects the slave
`timescale 1ns/1ps
`default_nettype none
module shrif_adapter_tb;
   localparam shrif_pkg::shrif_state_t s_noint = shrif_pkg::SHRIF_SEL_NOINT;
   localparam shrif_pkg::shrif_state_t s_int   = shrif_pkg::SHRIF_SEL_INT;
   localparam shrif_pkg::shrif_state_t s_nsel  = shrif_pkg::SHRIF_NOTSEL;
   localparam int wr_op = 0;
   localparam int rd_op = 1;
   localparam int cr_op = 2;
   logic       clk_sys_in, rst_n_in, host_wr_in, host_rd_in, host_ctl_in;
   logic       host_comreset_in, tl_upd_in, tl_ipf_in, host_rvalid_out;
   logic       host_intrq_out, link_comreset_out;
   logic       ctl_frame_req_out, cmd_frame_req_out;
   logic [2:0] host_addr_in, state_out;
   logic [7:0] host_wdata_in, tl_status_in, tl_devh_in, host_rdata_out;
   logic [7:0] frame_cmd_out, frame_devh_out, frame_dctl_out;
   int         miscompares, checks;

   shrif_adapter i_shrif_adapter (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
      .host_ctl_in(host_ctl_in), .host_addr_in(host_addr_in),
      .host_wdata_in(host_wdata_in), .host_comreset_in(host_comreset_in),
      .tl_upd_in(tl_upd_in), .tl_ipf_in(tl_ipf_in),
      .tl_status_in(tl_status_in), .tl_devh_in(tl_devh_in),
      .host_rdata_out(host_rdata_out), .host_rvalid_out(host_rvalid_out),
      .host_intrq_out(host_intrq_out), .link_comreset_out(link_comreset_out),
      .ctl_frame_req_out(ctl_frame_req_out),
      .cmd_frame_req_out(cmd_frame_req_out),
      .frame_cmd_out(frame_cmd_out), .frame_devh_out(frame_devh_out),
      .frame_dctl_out(frame_dctl_out), .state_out(state_out));

   shrif_tl_model i_shrif_tl_model (
      .clk_sys_in(clk_sys_in), .tl_upd_out(tl_upd_in),
      .tl_ipf_out(tl_ipf_in), .tl_status_out(tl_status_in),
      .tl_devh_out(tl_devh_in));

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk8

   // State, interrupt line and the three request pulses in one go
   task automatic chk_st(input shrif_pkg::shrif_state_t s,
                         input logic [2:0] p);
      chk8({5'h0, state_out}, {5'h0, s}, "state");
      chk8({7'h0, host_intrq_out}, {7'h0, s == s_int}, "intrq");
      chk8({5'h0, link_comreset_out, ctl_frame_req_out, cmd_frame_req_out},
           {5'h0, p}, "pulses");
   endtask : chk_st

   task automatic op(input int k, input logic c, input logic [2:0] a,
                     input logic [7:0] d);
      @(negedge clk_sys_in);
      host_wr_in       = (k == wr_op);
      host_rd_in       = (k == rd_op);
      host_comreset_in = (k == cr_op);
      host_ctl_in      = c;
      host_addr_in     = a;
      host_wdata_in    = d;
      @(negedge clk_sys_in);
      host_wr_in       = 1'b0;
      host_rd_in       = 1'b0;
      host_comreset_in = 1'b0;
   endtask : op

   task automatic rd(input logic c, input logic [2:0] a, input logic [7:0] e);
      op(rd_op, c, a, 8'h00);
      chk8({7'h0, host_rvalid_out}, 8'h01, "rvalid");
      chk8(host_rdata_out, e, "rdata");
   endtask : rd

   task automatic complete_run();
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   initial begin : watchdog
      repeat (5000) @(posedge clk_sys_in);
      miscompares++;
      $display("mismatch at %0t: run hung", $time);
      complete_run();
   end

   initial begin : main
      {host_wr_in, host_rd_in, host_ctl_in, host_comreset_in} = 4'h0;
      host_addr_in  = 3'h0;
      host_wdata_in = 8'h00;
      rst_n_in      = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      chk_st(s_noint, 3'b000);
      rd(1'b0, 3'h7, 8'h80);
      i_shrif_tl_model.send(1'b0, 8'h50, 8'h00, 0);
      chk_st(s_noint, 3'b000);
      rd(1'b0, 3'h7, 8'h50);
      op(wr_op, 1'b1, 3'h7, 8'h00);
      chk_st(s_noint, 3'b010);
      i_shrif_tl_model.send(1'b1, 8'h51, 8'h00, 3);
      chk_st(s_int, 3'b000);
      rd(1'b1, 3'h7, 8'h51);
      chk_st(s_int, 3'b000);
      op(wr_op, 1'b0, 3'h1, 8'h3c);
      chk_st(s_int, 3'b000);
      i_shrif_tl_model.send(1'b0, 8'h52, 8'h00, 0);
      chk_st(s_int, 3'b000);
      rd(1'b0, 3'h7, 8'h52);
      chk_st(s_noint, 3'b000);
      $display("test updates done");
      i_shrif_tl_model.send(1'b1, 8'h40, 8'h00, 0);
      op(wr_op, 1'b0, 3'h7, 8'hc8);
      chk_st(s_noint, 3'b001);
      chk8(frame_cmd_out, 8'hc8, "frame cmd");
      rd(1'b0, 3'h7, 8'hc0);
      op(wr_op, 1'b1, 3'h7, 8'h02);
      chk_st(s_noint, 3'b010);
      chk8(frame_dctl_out, 8'h02, "frame dctl");
      i_shrif_tl_model.send(1'b1, 8'h41, 8'h00, 0);
      chk_st(s_noint, 3'b000);
      op(wr_op, 1'b1, 3'h7, 8'h00);
      chk_st(s_int, 3'b010);
      op(wr_op, 1'b1, 3'h7, 8'h04);
      chk_st(s_noint, 3'b010);
      chk8(frame_dctl_out, 8'h04, "frame dctl");
      rd(1'b0, 3'h7, 8'hc1);
      $display("test commands done");
      op(wr_op, 1'b1, 3'h7, 8'h00);
      i_shrif_tl_model.send(1'b1, 8'h42, 8'h00, 0);
      op(wr_op, 1'b0, 3'h6, 8'h10);
      chk_st(s_nsel, 3'b000);
      i_shrif_tl_model.send(1'b1, 8'h43, 8'h10, 1);
      chk_st(s_nsel, 3'b000);
      rd(1'b0, 3'h7, 8'h00);
      rd(1'b1, 3'h7, 8'h00);
      op(wr_op, 1'b0, 3'h3, 8'ha5);
      chk_st(s_nsel, 3'b000);
      rd(1'b0, 3'h3, 8'ha5);
      op(wr_op, 1'b0, 3'h7, 8'hc8);
      chk_st(s_nsel, 3'b000);
      op(wr_op, 1'b1, 3'h7, 8'h00);
      chk_st(s_nsel, 3'b010);
      op(wr_op, 1'b0, 3'h6, 8'h00);
      chk_st(s_int, 3'b000);
      $display("test deselect done");
      op(cr_op, 1'b0, 3'h0, 8'h00);
      chk_st(s_noint, 3'b100);
      rd(1'b0, 3'h7, 8'hc3);
      op(wr_op, 1'b0, 3'h6, 8'h10);
      op(cr_op, 1'b0, 3'h0, 8'h00);
      chk_st(s_noint, 3'b100);
      rd(1'b0, 3'h6, 8'h00);
      op(wr_op, 1'b0, 3'h6, 8'h10);
      op(wr_op, 1'b1, 3'h7, 8'h04);
      chk_st(s_noint, 3'b010);
      rd(1'b0, 3'h6, 8'h00);
      op(wr_op, 1'b1, 3'h7, 8'h00);
      op(wr_op, 1'b0, 3'h6, 8'h10);
      op(wr_op, 1'b0, 3'h7, 8'h90);
      chk_st(s_noint, 3'b001);
      chk8(frame_devh_out, 8'h00, "frame devh");
      chk8(frame_cmd_out, 8'h90, "frame cmd");
      rd(1'b0, 3'h6, 8'h00);
      rd(1'b0, 3'h7, 8'hc3);
      $display("test resets done");
      complete_run();
   end
endmodule : shrif_adapter_tb
`default_nettype wire

// ---- dv/shrif_tl_model.sv ----
// Purpose: Transport side that hands device register updates to the adapter
// Assumes: Updates are one-cycle pulses launched on the falling edge
// Notes:   Idle data lines show the inverse of the last value, not a hold
`timescale 1ns/1ps
`default_nettype none
module shrif_tl_model (
   input  wire logic       clk_sys_in,
   output logic            tl_upd_out,
   output logic            tl_ipf_out,
   output logic      [7:0] tl_status_out,
   output logic      [7:0] tl_devh_out
);
   initial begin
      tl_upd_out    = 1'b0;
      tl_ipf_out    = 1'b1;
      tl_status_out = 8'hff;
      tl_devh_out   = 8'hff;
   end

   // A non-zero wait models a slow drive answering some cycles later
   task automatic send(input logic pending_interrupt_flag, input logic [7:0] st,
                       input logic [7:0] dh, input int dly);
      repeat (dly + 1) @(negedge clk_sys_in);
      tl_upd_out    = 1'b1;
      tl_ipf_out    = pending_interrupt_flag;
      tl_status_out = st;
      tl_devh_out   = dh;
      @(negedge clk_sys_in);
      tl_upd_out    = 1'b0;
      tl_ipf_out    = ~pending_interrupt_flag;
      tl_status_out = ~st;
      tl_devh_out   = ~dh;
   endtask : send
endmodule : shrif_tl_model
`default_nettype wire
